// *** design/modem_card.sv ***
// Card end: power state from the power pin, restart, radio and indicator outputs.
// Assumes pins are synchronous to clk; software radio command comes from the user side.
`timescale 1ns/1ps
module modem_card
	import sideband_pkg::*;
#(
	parameter int unsigned OFF_HOLD = OFF_HOLD_CYCLES,
	parameter int unsigned BOOT = BOOT_CYCLES
)
(
	input wire logic clk,
	input wire logic srst,
	sideband_if.card pins,
	input wire logic sw_radio_on,
	input wire logic wake_req,
	output logic powered,
	output logic running,
	output logic radio_on,
	output logic tx_backoff,
	output logic card_in,
	output logic card_inserted,
	output logic card_removed,
	output logic data_lost
);
	mod_state_t state_r;
	mod_state_t state_nxt;
	logic [CNT_W-1:0] boot_r;
	logic off_long;
	logic card_prev_r;
	logic running_nxt;

	// While running, power-off only counts as a full shutdown after a long low
	hold_timer #(.LIMIT(OFF_HOLD)) off_timer (
		.clk(clk),
		.srst(srst),
		.level(!pins.power_pin),
		.reached(off_long)
	);

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			MOD_OFF:
				if (pins.power_pin && pins.restart_pin_n)
					state_nxt = MOD_BOOT;
			MOD_BOOT:
				if (!pins.restart_pin_n)
					state_nxt = MOD_HOLD_RST;
				else if (!pins.power_pin)
					state_nxt = MOD_OFF;
				else if (boot_r == CNT_W'(BOOT))
					state_nxt = MOD_RUN;
			MOD_RUN:
				if (!pins.restart_pin_n)
					state_nxt = MOD_HOLD_RST;
				else if (off_long)
					state_nxt = MOD_OFF;
			MOD_HOLD_RST:
				if (pins.restart_pin_n)
					state_nxt = pins.power_pin ? MOD_BOOT : MOD_OFF;
			default:
				state_nxt = MOD_OFF;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			state_r <= MOD_OFF;
		else
			state_r <= state_nxt;
	end

	// Boot timer restarts on every entry to boot
	always_ff @(posedge clk)
	begin
		if (srst || state_r != MOD_BOOT)
			boot_r <= '0;
		else if (boot_r != CNT_W'(BOOT))
			boot_r <= boot_r + 1'b1;
	end

	assign running_nxt = (state_nxt == MOD_RUN);

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			powered <= 1'b0;
			running <= 1'b0;
			radio_on <= 1'b0;
			tx_backoff <= 1'b0;
			data_lost <= 1'b0;
			pins.status_lamp_oe <= 1'b0;
			pins.host_wake_oe <= 1'b0;
		end
		else
		begin
			powered <= (state_nxt != MOD_OFF);
			running <= running_nxt;
			// Pull-up in the card makes floating read high
			radio_on <= running_nxt && pins.radio_pin_n && sw_radio_on;
			tx_backoff <= running_nxt && !pins.proximity_backoff_n;
			data_lost <= (state_r != MOD_HOLD_RST) && (state_nxt == MOD_HOLD_RST);
			pins.status_lamp_oe <= running_nxt && pins.radio_pin_n && sw_radio_on;
			pins.host_wake_oe <= running_nxt && wake_req;
		end
	end

	// Card detect level, and its edges as one-cycle events
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			card_prev_r <= 1'b0;
			card_in <= 1'b0;
			card_inserted <= 1'b0;
			card_removed <= 1'b0;
		end
		else
		begin
			card_prev_r <= pins.card_present;
			card_in <= pins.card_present;
			card_inserted <= pins.card_present && !card_prev_r;
			card_removed <= !pins.card_present && card_prev_r;
		end
	end
endmodule

// *** design/sideband_pkg.sv ***
// Shared constants for the modem card sideband control pair.
// Assumes a single 25 MHz clock on both ends.
package sideband_pkg;
	localparam int unsigned CLK_HZ = 25000000;
	localparam int unsigned OFF_HOLD_MS = 500;
	localparam int unsigned RESTART_HOLD_MS = 20;
	localparam int unsigned MARGIN_MS = 10;
	localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
	localparam int unsigned OFF_HOLD_CYCLES = OFF_HOLD_MS * MS_CYCLES;
	localparam int unsigned RESTART_HOLD_CYCLES = RESTART_HOLD_MS * MS_CYCLES;
	localparam int unsigned HOST_OFF_CYCLES = (OFF_HOLD_MS + MARGIN_MS) * MS_CYCLES;
	localparam int unsigned HOST_RESTART_CYCLES = (RESTART_HOLD_MS + MARGIN_MS) * MS_CYCLES;
	localparam int unsigned BOOT_CYCLES = 64;
	localparam int unsigned CNT_W = 24;
	localparam logic RADIO_DEFAULT_ON = 1'b1;
	typedef enum logic [2:0] {MOD_OFF, MOD_BOOT, MOD_RUN, MOD_HOLD_RST} mod_state_t;
	typedef enum logic [2:0] {H_IDLE, H_ON, H_OFF_PULSE, H_RST_PULSE, H_CYCLE_LOW} host_state_t;
endpackage

// *** design/sideband_if.sv ***
// Sideband wires between host GPIO logic and the modem card.
// Open-drain outputs resolve here; pulls model the card's internal resistors.
`timescale 1ns/1ps
interface sideband_if;
	logic host_power_line;
	logic host_power_oe;
	logic host_restart_line;
	logic host_restart_oe;
	logic radio_disable_n;
	logic radio_disable_oe;
	logic proximity_backoff_n;
	logic card_present;
	logic status_lamp_oe;
	logic host_wake_oe;
	logic power_pin;
	logic restart_pin_n;
	logic radio_pin_n;
	logic status_lamp_n;
	logic host_wake_n;
	// Weak pull-down on power, pull-ups on restart and radio disable
	assign power_pin = host_power_oe ? host_power_line : 1'b0;
	assign restart_pin_n = host_restart_oe ? host_restart_line : 1'b1;
	assign radio_pin_n = radio_disable_oe ? radio_disable_n : 1'b1;
	assign status_lamp_n = ~status_lamp_oe;
	assign host_wake_n = ~host_wake_oe;
	modport card (input power_pin, input restart_pin_n, input radio_pin_n,
		input proximity_backoff_n, input card_present,
		output status_lamp_oe, output host_wake_oe);
	modport host (output host_power_line, output host_power_oe, output host_restart_line,
		output host_restart_oe, output radio_disable_n, output radio_disable_oe,
		output proximity_backoff_n, output card_present,
		input status_lamp_n, input host_wake_n);
endinterface

// *** design/hold_timer.sv ***
// Counts consecutive cycles a level is held; flags once a limit is reached.
// Assumes the level is already synchronous to clk.
`timescale 1ns/1ps
module hold_timer
	import sideband_pkg::*;
#(
	parameter int unsigned LIMIT = 16
)
(
	input wire logic clk,
	input wire logic srst,
	input wire logic level,
	output logic reached
);
	logic [CNT_W-1:0] cnt_r;
	always_ff @(posedge clk)
	begin
		if (srst || !level)
			cnt_r <= '0;
		else if (cnt_r != CNT_W'(LIMIT))
			cnt_r <= cnt_r + 1'b1;
	end
	assign reached = (cnt_r == CNT_W'(LIMIT));
endmodule

// *** design/host_ctrl.sv ***
// Host end: GPIO sequencer for power, restart and sideband levels.
// Assumes a single clk; the restart drive is direct, non-inverting by default.
`timescale 1ns/1ps
module host_ctrl
	import sideband_pkg::*;
#(
	parameter int unsigned OFF_HOLD = HOST_OFF_CYCLES,
	parameter int unsigned RST_HOLD = HOST_RESTART_CYCLES,
	parameter bit INVERT_RESTART = 1'b0
)
(
	input wire logic clk,
	input wire logic srst,
	sideband_if.host pins,
	input wire logic cmd_on,
	input wire logic cmd_off,
	input wire logic cmd_restart,
	input wire logic cmd_cycle,
	input wire logic radio_kill,
	input wire logic backoff_req,
	input wire logic sim_in,
	output logic busy,
	output logic lamp_lit,
	output logic wake_seen
);
	host_state_t state_r;
	host_state_t state_nxt;
	logic [CNT_W-1:0] cnt_r;
	logic pulse_done;

	assign pulse_done = (state_r == H_RST_PULSE) ? (cnt_r == CNT_W'(RST_HOLD))
		: (cnt_r == CNT_W'(OFF_HOLD));

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			H_IDLE:
				if (cmd_on)
					state_nxt = H_ON;
			H_ON:
				if (cmd_restart)
					state_nxt = H_RST_PULSE;
				else if (cmd_cycle)
					state_nxt = H_CYCLE_LOW;
				else if (cmd_off)
					state_nxt = H_OFF_PULSE;
			H_OFF_PULSE:
				if (pulse_done)
					state_nxt = H_IDLE;
			H_RST_PULSE, H_CYCLE_LOW:
				if (pulse_done)
					state_nxt = H_ON;
			default:
				state_nxt = H_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			state_r <= H_IDLE;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge clk)
	begin
		if (srst || state_nxt != state_r)
			cnt_r <= '0;
		else if (!pulse_done)
			cnt_r <= cnt_r + 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			pins.host_power_line <= 1'b0;
			pins.host_power_oe <= 1'b1;
			pins.host_restart_line <= !INVERT_RESTART;
			pins.host_restart_oe <= 1'b1;
			pins.radio_disable_n <= 1'b1;
			pins.radio_disable_oe <= 1'b0;
			pins.proximity_backoff_n <= 1'b1;
			pins.card_present <= 1'b0;
			busy <= 1'b0;
			lamp_lit <= 1'b0;
			wake_seen <= 1'b0;
		end
		else
		begin
			// Power held low except in on and restart pulse states
			pins.host_power_line <= (state_nxt == H_ON) || (state_nxt == H_RST_PULSE);
			// Released when idle; the card's pull-down keeps it off
			pins.host_power_oe <= (state_nxt != H_IDLE);
			// Released outside the pulse when INVERT_RESTART is clear, so the pull-up holds it high
			pins.host_restart_oe <= INVERT_RESTART || (state_nxt == H_RST_PULSE);
			// Restart stays released through power-up while INVERT_RESTART is clear
			pins.host_restart_line <= (state_nxt != H_RST_PULSE) ^ INVERT_RESTART;
			pins.radio_disable_n <= !radio_kill;
			pins.radio_disable_oe <= radio_kill;
			pins.proximity_backoff_n <= !backoff_req;
			pins.card_present <= sim_in;
			busy <= (state_nxt != H_IDLE) && (state_nxt != H_ON);
			lamp_lit <= !pins.status_lamp_n;
			wake_seen <= !pins.host_wake_n;
		end
	end
endmodule

// *** dv/sideband_sva.sv ***
// Checker on the sideband wires between the host and card ends.
// Assumes one clock; parameter defaults match the counts given to both ends.
`timescale 1ns/1ps
module sideband_sva
#(
	parameter int OFF_HOLD = 20,
	parameter int H_OFF = 25,
	parameter int H_RST = 10
)
(
	input logic clk,
	input logic srst,
	input logic power_pin,
	input logic restart_pin_n,
	input logic radio_pin_n,
	input logic status_lamp_n,
	input logic host_wake_n
);
	int lo_r;
	int fall_r;
	int rs_r;
	logic pwr_r;
	// The power width counts only from a real fall, so power-up from reset is not a pulse
	always_ff @(posedge clk)
	begin
		pwr_r <= power_pin;
		lo_r <= (srst || power_pin) ? 0 : lo_r + 1;
		fall_r <= (srst || power_pin) ? 0 : (pwr_r || fall_r != 0) ? fall_r + 1 : 0;
		rs_r <= (srst || restart_pin_n) ? 0 : rs_r + 1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	chk_reset_quiet: assert property ($fell(srst) |-> status_lamp_n && host_wake_n)
		else $error("card output active after reset");
	chk_restart_stops: assert property (!restart_pin_n [*4] |-> status_lamp_n)
		else $error("lamp lit during restart");
	chk_radio_kill: assert property (!radio_pin_n [*4] |-> status_lamp_n)
		else $error("lamp lit with radio disabled");
	chk_off_hold: assert property (lo_r > OFF_HOLD + 3 |-> status_lamp_n)
		else $error("card still on after long power low");
	chk_power_boot: assert property ($rose(power_pin) |-> status_lamp_n [*8])
		else $error("card running without boot");
	chk_restart_boot: assert property ($rose(restart_pin_n) |-> status_lamp_n [*8])
		else $error("card running without reboot");
	chk_restart_len: assert property (restart_pin_n && rs_r != 0 |-> rs_r == H_RST + 1)
		else $error("restart pulse width wrong");
	chk_cycle_len: assert property (power_pin && fall_r != 0 |-> fall_r == H_OFF + 1)
		else $error("power low pulse width wrong");
endmodule

// *** dv/tb.sv ***
// Bench joining host and card ends through the sideband interface.
// Assumes shortened hold and boot counts; the checker watches the wires.
`timescale 1ns/1ps
module tb;
	logic clk = 0;
	logic srst = 1, sw_radio_on = 1, wake_req = 0, cmd_on = 0, cmd_off = 0;
	logic cmd_restart = 0, cmd_cycle = 0, radio_kill = 0, backoff_req = 0, sim_in = 0;
	logic powered, running, radio_on, tx_backoff, card_in, card_inserted, card_removed;
	logic data_lost, busy, lamp_lit, wake_seen;
	int n_mismatch = 0, samples_checked = 0, n_lost = 0, n_ins = 0, n_rem = 0;
	sideband_if sb();
	modem_card #(.OFF_HOLD(20), .BOOT(8)) i_modem_card (.clk, .srst, .pins(sb),
		.sw_radio_on, .wake_req, .powered, .running, .radio_on, .tx_backoff,
		.card_in, .card_inserted, .card_removed, .data_lost);
	host_ctrl #(.OFF_HOLD(25), .RST_HOLD(10)) i_host_ctrl (.clk, .srst, .pins(sb),
		.cmd_on, .cmd_off, .cmd_restart, .cmd_cycle, .radio_kill, .backoff_req,
		.sim_in, .busy, .lamp_lit, .wake_seen);
	sideband_sva i_sideband_sva (.clk, .srst,
		.power_pin(sb.power_pin), .restart_pin_n(sb.restart_pin_n),
		.radio_pin_n(sb.radio_pin_n), .status_lamp_n(sb.status_lamp_n),
		.host_wake_n(sb.host_wake_n));
	always #20 clk = ~clk;
	// Counting high cycles also proves each pulse lasts one cycle
	always @(posedge clk)
	begin
		n_lost += (data_lost === 1'b1);
		n_ins += (card_inserted === 1'b1);
		n_rem += (card_removed === 1'b1);
	end
	task automatic step(input int n = 1);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		step();
		s = 0;
	endtask
	task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %0h seen %0h", nm, exp, got);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic wait_for(input logic [1:0] want);
		int i;
		for (i = 0; i < 400 && {powered, running} !== want; i++)
			step();
		check("power state", {powered, running}, want);
		// A miss already counted; later scenarios would only cascade
		if ({powered, running} !== want)
			report_and_stop();
	endtask
	task automatic t_power_on();
		check("powered", powered, 0);
		pulse(cmd_on);
		wait_for(2'b11);
		step(2);
		check("radio_on", radio_on, 1);
		check("lamp_lit", lamp_lit, 1);
		check("tx_backoff", tx_backoff, 0);
	endtask
	task automatic t_sideband();
		radio_kill = 1;
		backoff_req = 1;
		wake_req = 1;
		sim_in = 1;
		step(6);
		check("radio_on", radio_on, 0);
		check("lamp_lit", lamp_lit, 0);
		check("tx_backoff", tx_backoff, 1);
		check("wake_seen", wake_seen, 1);
		check("card_in", card_in, 1);
		check("inserted", n_ins, 1);
		radio_kill = 0;
		backoff_req = 0;
		wake_req = 0;
		sim_in = 0;
		step(6);
		check("radio_on", radio_on, 1);
		check("wake_seen", wake_seen, 0);
		check("removed", n_rem, 1);
	endtask
	task automatic t_sw_radio();
		sw_radio_on = 0;
		step(4);
		check("radio_on", radio_on, 0);
		check("lamp_lit", lamp_lit, 0);
		sw_radio_on = 1;
		step(4);
		check("radio_on", radio_on, 1);
		check("lamp_lit", lamp_lit, 1);
	endtask
	task automatic t_restart();
		pulse(cmd_restart);
		wait_for(2'b10);
		check("busy", busy, 1);
		wait_for(2'b11);
		check("lost", n_lost, 1);
		check("busy", busy, 0);
	endtask
	task automatic t_cycle();
		pulse(cmd_cycle);
		step();
		// An off request while busy must be ignored, or power never returns
		pulse(cmd_off);
		wait_for(2'b00);
		check("busy", busy, 1);
		wait_for(2'b11);
	endtask
	task automatic t_off();
		pulse(cmd_off);
		wait_for(2'b00);
		step(40);
		check("powered", powered, 0);
		check("busy", busy, 0);
	endtask
	initial
	begin
		step(10);
		srst = 0;
		t_power_on();
		t_sideband();
		t_sw_radio();
		t_restart();
		t_cycle();
		t_off();
		report_and_stop();
	end
endmodule
